// ==== verification/pddr_board.sv ====
// Board model: pin levels seen by the port, external drivers on input pins
`timescale 1ns/1ns
`default_nettype none
module pddr_board (
  input  wire logic [7:0] pin_drv_i,
  input  wire logic [7:0] pin_oen_n_i,
  input  wire logic [7:0] ext_lvl_i,
  output logic      [7:0] pin_lvl_o
);
  // ****************
  // Pin resolution
  // ****************
  // A pin the port drives shows the port level; others show the board driver
  assign pin_lvl_o = (~pin_oen_n_i & pin_drv_i) | (pin_oen_n_i & ext_lvl_i);
endmodule // pddr_board
`default_nettype wire

// ==== verification/port_data_direction_readback_tb.sv ====
// Self-checking bench of the port data and direction block
`timescale 1ns/1ns
`default_nettype none
module port_data_direction_readback_tb;
  import pddr_pkg::*;
  logic       clk_i = 1'b0;
  logic       resetn_i = 1'b0;
  logic       ce_i = 1'b1;
  logic       req_valid_i = 1'b0;
  pddr_req_t  req_i = '0;
  logic [7:0] ext_lvl = 8'h40;
  logic [7:0] pin_lvl, pin_o, pin_oen_n, rdata;
  logic       rvalid, busy;
  int         fails = 0;
  int         cmp_count = 0;
  int         cycles = 0;
  // ****************
  // Harness
  // ****************
  initial forever #4 clk_i = ~clk_i;
  pddr_board board (.pin_drv_i(pin_o), .pin_oen_n_i(pin_oen_n), .ext_lvl_i(ext_lvl), .pin_lvl_o(pin_lvl));
  pddr_port dut (.CLK_I(clk_i), .RESETN_I(resetn_i), .CE_I(ce_i), .REQ_VALID_I(req_valid_i), .REQ_I(req_i),
    .PIN_I(pin_lvl), .PIN_O(pin_o), .PIN_OEN_O(pin_oen_n), .RDATA_O(rdata), .RVALID_O(rvalid), .BUSY_O(busy));
  task automatic test_done;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // A hung handshake must still reach the verdict
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      test_done();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // ****************
  // Request tasks
  // ****************
  task automatic req(input pddr_op_t op, input logic sel, input logic [2:0] b, input logic [7:0] d);
    @(posedge clk_i);
    req_valid_i <= 1'b1;
    req_i <= '{op: op, sel: sel, bit_idx: b, wdata: d};
    @(posedge clk_i);
    req_valid_i <= 1'b0;
  endtask
  task automatic wr(input logic sel, input logic [7:0] d);
    req(PDDR_OP_WRITE, sel, 3'h0, d);
    repeat (2) @(posedge clk_i);
    #1;
  endtask
  task automatic rd(input logic sel, output logic [7:0] got);
    int n;
    n = 0;
    req(PDDR_OP_READ, sel, 3'h0, 8'h00);
    #1;
    while (rvalid !== 1'b1 && n < 4) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk({7'h00, rvalid}, 8'h01);
    got = rdata;
  endtask
  task automatic bitop(input pddr_op_t op, input logic sel, input logic [2:0] b);
    req(op, sel, b, 8'h00);
    @(posedge clk_i);
    #1;
    chk({7'h00, busy}, 8'h01);
    repeat (3) @(posedge clk_i);
    #1;
    chk({7'h00, busy}, 8'h00);
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic sc_reset_state;
    chk(pin_oen_n, 8'hff);
    chk(pin_o, 8'h00);
  endtask
  task automatic sc_dir_readback;
    logic [7:0] got;
    rd(1'b1, got);
    chk(got, 8'hff);
    wr(1'b1, 8'h3f);
    chk(pin_oen_n, 8'hc0);
    rd(1'b1, got);
    chk(got, 8'hff);
  endtask
  task automatic sc_byte_write;
    wr(1'b0, 8'h80);
    chk(pin_o, 8'h80);
    chk(pin_o & ~pin_oen_n, 8'h00);
  endtask
  task automatic sc_single_bit_set_op_pins;
    logic [7:0] got;
    rd(1'b0, got);
    chk(got, 8'h40);
    bitop(PDDR_OP_SINGLE_BIT_SET_OP, 1'b0, 3'h0);
    chk(pin_o, 8'h41);
  endtask
  // Shadow copy writes keep the input-pin latch bits; the later bit clear reloads them from the pins
  task automatic sc_shadow_copy;
    logic [7:0] shadow_work_area;
    shadow_work_area = 8'h80;
    wr(1'b0, shadow_work_area);
    shadow_work_area = shadow_work_area | 8'h01;
    wr(1'b0, shadow_work_area);
    chk(pin_o, 8'h81);
    bitop(PDDR_OP_SINGLE_BIT_CLEAR_OP, 1'b0, 3'h0);
    chk(pin_o, 8'h40);
  endtask
  task automatic sc_dir_single_bit_clear_op;
    logic [7:0] got;
    bitop(PDDR_OP_SINGLE_BIT_CLEAR_OP, 1'b1, 3'h0);
    chk(pin_oen_n, 8'h01);
    @(posedge clk_i);
    ext_lvl <= 8'h01;
    rd(1'b0, got);
    chk(got, 8'h41);
  endtask
  // A write that arrives during write-back is dropped; the set bit turns 41 into 43
  task automatic sc_busy_refused;
    req(PDDR_OP_SINGLE_BIT_SET_OP, 1'b0, 3'h1, 8'h00);
    req(PDDR_OP_WRITE, 1'b0, 3'h0, 8'hff);
    repeat (2) @(posedge clk_i);
    #1;
    chk({7'h00, busy}, 8'h00);
    chk(pin_o, 8'h43);
  endtask
  task automatic sc_ce_freeze;
    @(posedge clk_i);
    ce_i <= 1'b0;
    req(PDDR_OP_WRITE, 1'b0, 3'h0, 8'h00);
    repeat (2) @(posedge clk_i);
    #1;
    chk(pin_o, 8'h43);
    @(posedge clk_i);
    ce_i <= 1'b1;
    wr(1'b0, 8'h0c);
    chk(pin_o, 8'h0c);
  endtask
  task automatic sc_mid_reset;
    logic [7:0] got;
    @(posedge clk_i);
    resetn_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    resetn_i <= 1'b1;
    #1;
    chk(pin_oen_n, 8'hff);
    chk(pin_o, 8'h00);
    rd(1'b0, got);
    chk(got, 8'h01);
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    resetn_i <= 1'b1;
    #1;
    sc_reset_state();
    sc_dir_readback();
    sc_byte_write();
    sc_single_bit_set_op_pins();
    sc_shadow_copy();
    sc_dir_single_bit_clear_op();
    sc_busy_refused();
    sc_ce_freeze();
    sc_mid_reset();
    test_done();
  end
endmodule // port_data_direction_readback_tb
`default_nettype wire

// ==== verilog/pddr_defs.svh ====
// Constants of the port data and direction block
// What this block does
// - Data read returns pin level for every input-configured bit.
// - Data read returns latch value for every output-configured bit.
// - Bit set reads byte, forces one bit high, writes whole byte back.
// - Byte write to data register also updates latches of input pins.
// - Output pins drive their latch bit, following writes at once.
// - Direction bit zero means input, one means output.
// - Direction register is write-only and always reads as all ones.
// - Every port access moves exactly one byte over an 8-bit path.
`ifndef PDDR_DEFS_SVH
`define PDDR_DEFS_SVH
`define PDDR_WIDTH        8
`define PDDR_SEL_DATA     1'b0
`define PDDR_SEL_DIR      1'b1
`define PDDR_DIR_READBACK 8'hff
`define PDDR_DATA_RESET   8'h00
`define PDDR_DIR_RESET    8'h00
`endif

// ==== verilog/pddr_pkg.sv ====
// Types of the port data and direction block
`default_nettype none
`include "pddr_defs.svh"
package pddr_pkg;
  typedef enum logic [1:0] {
    PDDR_OP_READ  = 2'b00,
    PDDR_OP_WRITE = 2'b01,
    PDDR_OP_SINGLE_BIT_SET_OP  = 2'b10,
    PDDR_OP_SINGLE_BIT_CLEAR_OP  = 2'b11
  } pddr_op_t;
  typedef enum logic [1:0] {
    PDDR_ST_IDLE   = 2'b00,
    PDDR_ST_MODIFY = 2'b01,
    PDDR_ST_WRITE  = 2'b10
  } pddr_state_t;
  typedef struct packed {
    pddr_op_t   op;
    logic       sel;
    logic [2:0] bit_idx;
    logic [7:0] wdata;
  } pddr_req_t;
endpackage
`default_nettype wire

// ==== verilog/pddr_port.sv ====
// Eight-pin port with direction control, readback and read-modify-write bit ops
`timescale 1ns/1ns
`default_nettype none
`include "pddr_defs.svh"
module pddr_port
  import pddr_pkg::*;
#(
  parameter int WIDTH = `PDDR_WIDTH
) (
  input  wire logic        CLK_I,
  input  wire logic        RESETN_I,
  input  wire logic        CE_I,
  input  wire logic        REQ_VALID_I,
  input  wire pddr_req_t   REQ_I,
  input  wire logic [7:0]  PIN_I,
  output logic      [7:0]  PIN_O,
  output logic      [7:0]  PIN_OEN_O,
  output logic      [7:0]  RDATA_O,
  output logic             RVALID_O,
  output logic             BUSY_O
);
  // ************************************************************
  // Parameter check
  // ************************************************************
  // Elaboration stops here for any width but one byte
  if (WIDTH != `PDDR_WIDTH) begin : g_width_check
    $error("pddr_port serves an 8-bit path only");
  end

  // ************************************************************
  // State
  // ************************************************************
  logic [7:0]  pin_output_latch_r, pin_output_latch_nxt;
  logic [7:0]  pin_direction_control_r, pin_direction_control_nxt;
  logic [7:0]  rdata_r, rdata_nxt;
  logic        rvalid_r, rvalid_nxt;
  pddr_state_t state_r, state_nxt;
  pddr_req_t   held_r, held_nxt;
  logic [7:0]  work_r, work_nxt;

  // Readback: output bits show the latch, input bits the live pin
  function automatic logic [7:0] read_byte(input logic sel, input logic [7:0] dir,
                                           input logic [7:0] lat, input logic [7:0] pin);
    if (sel == `PDDR_SEL_DIR) begin
      read_byte = `PDDR_DIR_READBACK;
    end else begin
      read_byte = (dir & lat) | (~dir & pin);
    end
  endfunction

  always_comb begin
    pin_output_latch_nxt      = pin_output_latch_r;
    pin_direction_control_nxt = pin_direction_control_r;
    rdata_nxt                 = rdata_r;
    rvalid_nxt                = 1'b0;
    state_nxt                 = state_r;
    held_nxt                  = held_r;
    work_nxt                  = work_r;
    case (state_r)
      PDDR_ST_IDLE: begin
        if (REQ_VALID_I) begin
          held_nxt = REQ_I;
          if (REQ_I.op == PDDR_OP_READ) begin
            rdata_nxt  = read_byte(REQ_I.sel, pin_direction_control_r, pin_output_latch_r, PIN_I);
            rvalid_nxt = 1'b1;
          end else if (REQ_I.op == PDDR_OP_WRITE) begin
            // Whole byte lands, input-pin latches included
            if (REQ_I.sel == `PDDR_SEL_DIR) begin
              pin_direction_control_nxt = REQ_I.wdata;
            end else begin
              pin_output_latch_nxt = REQ_I.wdata;
            end
          end else begin
            // Read phase of bit op: same readback as a plain read
            work_nxt  = read_byte(REQ_I.sel, pin_direction_control_r, pin_output_latch_r, PIN_I);
            state_nxt = PDDR_ST_MODIFY;
          end
        end
      end
      PDDR_ST_MODIFY: begin
        // Only the named bit changes; the rest is whatever the read phase saw
        if (held_r.op == PDDR_OP_SINGLE_BIT_SET_OP) begin
          work_nxt = work_r | (8'h01 << held_r.bit_idx);
        end else begin
          work_nxt = work_r & ~(8'h01 << held_r.bit_idx);
        end
        state_nxt = PDDR_ST_WRITE;
      end
      PDDR_ST_WRITE: begin
        // Write-back of the full byte; a direction target sees ones from readback
        if (held_r.sel == `PDDR_SEL_DIR) begin
          pin_direction_control_nxt = work_r;
        end else begin
          pin_output_latch_nxt = work_r;
        end
        state_nxt = PDDR_ST_IDLE;
      end
      default: begin
        state_nxt = PDDR_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      pin_output_latch_r      <= `PDDR_DATA_RESET;
      pin_direction_control_r <= `PDDR_DIR_RESET;
      rdata_r                 <= 8'h00;
      rvalid_r                <= 1'b0;
      state_r                 <= PDDR_ST_IDLE;
      held_r                  <= '0;
      work_r                  <= 8'h00;
    end else if (CE_I) begin
      pin_output_latch_r      <= pin_output_latch_nxt;
      pin_direction_control_r <= pin_direction_control_nxt;
      rdata_r                 <= rdata_nxt;
      rvalid_r                <= rvalid_nxt;
      state_r                 <= state_nxt;
      held_r                  <= held_nxt;
      work_r                  <= work_nxt;
    end
  end

  // ************************************************************
  // Pin drivers, registered so outputs come from flops
  // ************************************************************
  // Fed from the next values so a write reaches the pins on the same edge
  // as the latch, with no extra cycle of lag
  logic [7:0] pin_o_r, pin_o_nxt;
  logic [7:0] pin_oen_r, pin_oen_nxt;
  logic       busy_r, busy_nxt;

  always_comb begin
    pin_o_nxt   = pin_output_latch_nxt;
    pin_oen_nxt = ~pin_direction_control_nxt;
    busy_nxt    = (state_nxt != PDDR_ST_IDLE);
  end

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      pin_o_r   <= `PDDR_DATA_RESET;
      pin_oen_r <= ~`PDDR_DIR_RESET;
      busy_r    <= 1'b0;
    end else if (CE_I) begin
      pin_o_r   <= pin_o_nxt;
      pin_oen_r <= pin_oen_nxt;
      busy_r    <= busy_nxt;
    end
  end

  assign PIN_O     = pin_o_r;
  assign PIN_OEN_O = pin_oen_r;
  assign RDATA_O   = rdata_r;
  assign RVALID_O  = rvalid_r;
  assign BUSY_O    = busy_r;

  // ************************************************************
  // Checks
  // ************************************************************
  chk_dir_readback: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (CE_I && REQ_VALID_I && state_r == PDDR_ST_IDLE && REQ_I.op == PDDR_OP_READ && REQ_I.sel)
    |=> (RDATA_O == 8'hff && RVALID_O)) else $error("direction read not all ones");
  chk_data_readback: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (CE_I && REQ_VALID_I && state_r == PDDR_ST_IDLE && REQ_I.op == PDDR_OP_READ && !REQ_I.sel)
    |=> (RDATA_O == (($past(pin_direction_control_r) & $past(pin_output_latch_r))
                    | (~$past(pin_direction_control_r) & $past(PIN_I)))))
    else $error("data readback mixes pins and latch wrongly");
  chk_pin_follow: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (PIN_O == pin_output_latch_r)) else $error("pin drive differs from latch");
  chk_oen_dir: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (PIN_OEN_O == ~pin_direction_control_r)) else $error("enable differs from direction");
  chk_write_data: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (CE_I && REQ_VALID_I && state_r == PDDR_ST_IDLE && REQ_I.op == PDDR_OP_WRITE && !REQ_I.sel)
    |=> (pin_output_latch_r == $past(REQ_I.wdata) && PIN_O == $past(REQ_I.wdata)))
    else $error("byte write not taken whole");
  chk_bitop_seq: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (CE_I && state_r == PDDR_ST_MODIFY) ##1 (CE_I [*2])
    |-> (state_r == PDDR_ST_IDLE && BUSY_O == 1'b0)) else $error("bit op did not finish");
  chk_single_bit_set_op_bit: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (CE_I && state_r == PDDR_ST_MODIFY && held_r.op == PDDR_OP_SINGLE_BIT_SET_OP && !held_r.sel) ##1 CE_I
    |=> pin_output_latch_r[$past(held_r.bit_idx, 2)]) else $error("set bit not one after write");
  chk_dir_single_bit_clear_op: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (CE_I && state_r == PDDR_ST_MODIFY && held_r.op == PDDR_OP_SINGLE_BIT_CLEAR_OP && held_r.sel) ##1 CE_I
    |=> ($countones(pin_direction_control_r) == 7)) else $error("clear on direction wrong");

  // ************************************************************
  // Bit operation, direction write, read valid and enable checks
  // ************************************************************
  // The read phase of a bit op sees the same pin and latch mix as a plain read
  chk_bitop_read: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (CE_I && REQ_VALID_I && state_r == PDDR_ST_IDLE && !REQ_I.sel
     && (REQ_I.op == PDDR_OP_SINGLE_BIT_SET_OP || REQ_I.op == PDDR_OP_SINGLE_BIT_CLEAR_OP))
    |=> (work_r == (($past(pin_direction_control_r) & $past(pin_output_latch_r))
                   | (~$past(pin_direction_control_r) & $past(PIN_I)))))
    else $error("bit op read phase took the wrong byte");
  chk_bitop_busy: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (CE_I && REQ_VALID_I && state_r == PDDR_ST_IDLE
     && (REQ_I.op == PDDR_OP_SINGLE_BIT_SET_OP || REQ_I.op == PDDR_OP_SINGLE_BIT_CLEAR_OP))
    |=> (BUSY_O && state_r == PDDR_ST_MODIFY)) else $error("bit op did not raise busy");
  chk_single_bit_clear_op_bit: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (CE_I && state_r == PDDR_ST_MODIFY && held_r.op == PDDR_OP_SINGLE_BIT_CLEAR_OP && !held_r.sel) ##1 CE_I
    |=> !pin_output_latch_r[$past(held_r.bit_idx, 2)]) else $error("cleared bit not zero after write");
  // Write-back must reach the pins on the same edge as the latch
  chk_bitop_pins: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (CE_I && state_r == PDDR_ST_WRITE && !held_r.sel)
    |=> (PIN_O == $past(work_r) && pin_output_latch_r == $past(work_r)))
    else $error("write-back not on the pins");
  // A request that lands during write-back is dropped; the modified byte wins
  chk_busy_refuse: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (CE_I && REQ_VALID_I && state_r == PDDR_ST_WRITE && !held_r.sel)
    |=> (pin_output_latch_r == $past(work_r) && !RVALID_O)) else $error("request taken while busy");
  chk_dir_write: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (CE_I && REQ_VALID_I && state_r == PDDR_ST_IDLE && REQ_I.op == PDDR_OP_WRITE && REQ_I.sel)
    |=> (PIN_OEN_O == ~$past(REQ_I.wdata))) else $error("direction write not taken whole");
  // Read data is only flagged for a read taken on the previous edge
  chk_rvalid_read: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (CE_I && !(REQ_VALID_I && state_r == PDDR_ST_IDLE && REQ_I.op == PDDR_OP_READ))
    |=> !RVALID_O) else $error("read valid without a read");
  // Low enable freezes every register, so the pins hold too
  chk_ce_freeze: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    !CE_I |=> ($stable(pin_output_latch_r) && $stable(pin_direction_control_r)
              && $stable(state_r) && $stable(PIN_O))) else $error("state moved with enable low");
endmodule // pddr_port
`default_nettype wire
